// ===== design/su2_pkg.sv
// package: register map, field positions, reset values and timing for the serial-2 block
package su2_pkg;
  // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [7:0]  IDX_AUX_CONTROL      = 8'h8E;
  localparam logic [7:0]  IDX_SERIAL2_CONTROL  = 8'h9A;
  localparam logic [7:0]  IDX_SERIAL2_BUFFER   = 8'h9B;
  localparam logic [7:0]  IDX_BAUD_RELOAD      = 8'h9C;
  localparam logic [7:0]  IDX_INT_ENABLE       = 8'hA8;
  localparam logic [7:0]  IDX_INT_ENABLE2      = 8'hAF;
  localparam logic [7:0]  IDX_PRIO_LOW         = 8'hB5;
  localparam logic [7:0]  IDX_PRIO_HIGH        = 8'hB6;
  // serial2_control fields
  localparam int          CTL_MODE_HI          = 7;
  localparam int          CTL_MODE_LO          = 6;
  localparam int          CTL_ADDR_REC         = 5;
  localparam int          CTL_RX_EN            = 4;
  localparam int          CTL_TX_NINTH         = 3;
  localparam int          CTL_RX_NINTH         = 2;
  localparam int          CTL_TX_DONE          = 1;
  localparam int          CTL_RX_DONE          = 0;
  // aux_control fields, then interrupt enable and priority bit positions
  localparam int          AUX_RUN              = 4;
  localparam int          AUX_DOUBLE           = 3;
  localparam int          AUX_SPEED            = 2;
  localparam int          AUX_S1_SRC           = 0;
  localparam int          IE_GLOBAL            = 7;
  localparam int          IE2_SERIAL2          = 0;
  localparam int          PRIO_SERIAL2         = 0;
  // reset values and write masks
  localparam logic [7:0]  RST_BYTE             = 8'h00;
  localparam logic [7:0]  IE_WMASK             = 8'hBF;
  localparam logic [7:0]  IE2_WMASK            = 8'h03;
  // timing and address match values
  localparam int          PRESCALE_12          = 12;
  localparam int          BRT_DIV              = 16;
  localparam int          MODE2_DIV            = 32;
  localparam int          OVS                  = 16;
  localparam int          SHIFT_HALF           = 6;
  localparam logic [7:0]  DEF_OWN_ADDR         = 8'h00;
  localparam logic [7:0]  BROADCAST_ADDR       = 8'hFF;

  typedef enum logic [3:0] {
    SU2_MODE_SHIFT = 4'h1,
    SU2_MODE_UART8 = 4'h2,
    SU2_MODE_FIX9  = 4'h4,
    SU2_MODE_VAR9  = 4'h8
  } su2_mode_t;

  typedef struct packed {
    logic       run;
    logic       dbl;
    logic       speed;
    logic [7:0] reload;
  } su2_baud_cfg_t;

  typedef struct packed {
    logic       global_en;
    logic       serial2_en;
    logic [1:0] prio;
  } su2_irq_cfg_t;
endpackage

// ===== design/su2_baud_gen.sv
// dedicated 8-bit auto-reload baud timer with x1/x12 prescale
`timescale 1ns/1ps
module su2_baud_gen (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // configuration
  input  wire su2_pkg::su2_baud_cfg_t cfg_i,
  // overflow pulse
  output logic                   ovf_o
);
  logic [3:0] pre_r;
  logic [7:0] cnt_r;
  logic       tick;

  assign tick = cfg_i.speed | (pre_r == 4'(su2_pkg::PRESCALE_12 - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !cfg_i.run || cfg_i.speed || tick) begin
      pre_r <= 4'h0;
    end else begin
      pre_r <= pre_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= 1'b0;
      if (cfg_i.run && tick) begin
        if (cnt_r == 8'hFF) begin
          cnt_r <= cfg_i.reload;
          ovf_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

  property p_stop_no_ovf;
    @(posedge clk_i) disable iff (!rst_b_i) !cfg_i.run ##1 !cfg_i.run |-> !ovf_o;
  endproperty
  a_stop_no_ovf: assert property (p_stop_no_ovf) else $error("overflow while stopped");
endmodule

// ===== design/su2_rate_div.sv
// divider turning a tick stream into bit-sample ticks
`timescale 1ns/1ps
module su2_rate_div #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // tick in, division factor minus one
  input  wire logic         tick_i,
  input  wire logic [W-1:0] limit_i,
  // divided tick
  output logic              tick_o
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (cnt_r >= limit_i) begin
          cnt_r  <= '0;
          tick_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule

// ===== design/su2_uart.sv
// secondary serial port with APB registers, baud timer and interrupt request
//
// Operation
// - mode field picks shift register, 8-bit UART, fixed 9-bit, variable 9-bit
// - modes 1/3 run at overflow/32, mode 2 at clock/64, doubled by flag
// - baud timer overflows every 256 minus reload counts
// - address recognition in modes 2/3 needs ninth bit 1 and address match
// - address recognition in mode 1 needs valid stop bit and address match
// - reception only while receive enable is set
// - modes 2/3 send the transmit ninth bit as ninth data bit
// - modes 2/3 store the received ninth bit
// - transmit-done flag set by hardware at frame end
// - receive-done flag set by hardware at frame end
// - writing the data buffer loads and starts transmission
// - reading the data buffer returns the receive latch
// - reload register reloads the baud timer on overflow
// - baud timer counts only while its run bit is set
// - doubling bit doubles the rate, default off
// - timer steps every 12 clocks or every clock by speed select
// - serial-2 modes 1/3 always time from the dedicated baud timer
// - first port uses timer 1 unless the source-select bit is set
// - nothing acknowledged while the global enable is clear
// - serial-2 interrupt raised only while its enable is set
// - priority is high bit and low bit forming 0 to 3
// - mode 0 shifts data on receive pin, clock on transmit pin, lsb first; the clock runs only during a transmit, so reception shifts only then
// - mode 1 frame is start, eight data, stop
// - mode 1 reception stores the stop bit as the ninth bit
// - modes 2/3 frame is start, eight data, ninth bit, stop
`timescale 1ns/1ps
module su2_uart #(
  parameter logic [7:0] OWN_ADDR = su2_pkg::DEF_OWN_ADDR
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // serial pins
  input  wire logic        rx_i,
  output logic             rx_o,
  output logic             rx_oe_o,
  output logic             tx_o,
  // interrupt and baud source outputs
  output logic             irq_o,
  output logic [1:0]       irq_prio_o,
  output logic             s1_use_brt_o,
  output logic             brt_ovf_o
);
  logic [7:0] aux_r, ctl_r, reload_r, ie_r, ie2_r, pl_r, ph_r, rx_latch_r;
  logic       access, wr, hit;
  logic [9:0] idx;
  logic       clr_tx, clr_rx, set_tx, set_rx, set_rb8, rb8_val;
  su2_pkg::su2_mode_t mode;
  su2_pkg::su2_baud_cfg_t bcfg;
  logic       ovf, bit16, m0_tick;
  logic [3:0] pre_m0_r;
  logic       shift_edge;

  assign access = psel_i & penable_i;
  assign idx    = paddr_i[11:2];
  assign wr     = access & pwrite_i;
  always_comb begin
    unique case ({ctl_r[su2_pkg::CTL_MODE_HI], ctl_r[su2_pkg::CTL_MODE_LO]})
      2'b00:   mode = su2_pkg::SU2_MODE_SHIFT;
      2'b01:   mode = su2_pkg::SU2_MODE_UART8;
      2'b10:   mode = su2_pkg::SU2_MODE_FIX9;
      2'b11:   mode = su2_pkg::SU2_MODE_VAR9;
    endcase
  end

  assign bcfg.run    = aux_r[su2_pkg::AUX_RUN];
  assign bcfg.dbl    = aux_r[su2_pkg::AUX_DOUBLE];
  assign bcfg.speed  = aux_r[su2_pkg::AUX_SPEED];
  assign bcfg.reload = reload_r;

  // baud source: serial-2 modes 1/3 always on the dedicated timer
  su2_baud_gen u_brt (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .cfg_i   (bcfg),
    .ovf_o   (ovf)
  );

  // two samples per bit; brt path divides by 16 (x2 -> 32), fixed by 32 (x2 -> 64)
  logic [5:0] div_lim;
  logic       div_in;
  always_comb begin
    if (mode == su2_pkg::SU2_MODE_FIX9) begin
      div_in  = 1'b1;
      div_lim = 6'(bcfg.dbl ? su2_pkg::MODE2_DIV / 2 - 1 : su2_pkg::MODE2_DIV - 1);
    end else begin
      div_in  = ovf;
      div_lim = 6'(bcfg.dbl ? su2_pkg::BRT_DIV / 2 - 1 : su2_pkg::BRT_DIV - 1);
    end
  end
  // bit rate = source / (2 * (limit + 1))
  logic samp;
  su2_rate_div #(.W(6)) u_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (div_in),
    .limit_i (div_lim),
    .tick_o  (samp)
  );
  // one bit spans two samples: overflow/32 undoubled
  logic half_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      half_r <= 1'b0;
    end else if (samp) begin
      half_r <= ~half_r;
    end
  end
  assign bit16 = samp & half_r;

  // mode 0 clock: system clock / 12, half period 6
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || m0_tick) begin
      pre_m0_r <= 4'h0;
    end else begin
      pre_m0_r <= pre_m0_r + 4'h1;
    end
  end
  assign m0_tick = (pre_m0_r == 4'(su2_pkg::SHIFT_HALF - 1));

  // ---------------- transmitter ----------------
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_cnt_r;
  logic        tx_busy_r, m0_clk_r, tx_go_r;
  logic        tx_wr;
  assign tx_wr = wr && idx == 10'(su2_pkg::IDX_SERIAL2_BUFFER);
  assign shift_edge = (mode == su2_pkg::SU2_MODE_SHIFT) ? m0_tick : bit16;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_sh_r   <= 11'h7FF;
      tx_cnt_r  <= 4'h0;
      tx_busy_r <= 1'b0;
      m0_clk_r  <= 1'b1;
      tx_go_r   <= 1'b0;
      set_tx    <= 1'b0;
    end else begin
      set_tx <= 1'b0;
      if (tx_wr) begin
        tx_go_r   <= 1'b0;
        tx_busy_r <= 1'b1;
        m0_clk_r  <= 1'b1;
        unique case (mode)
          su2_pkg::SU2_MODE_SHIFT: begin
            tx_sh_r  <= {3'b111, pwdata_i[7:0]};
            tx_cnt_r <= 4'd8;
          end
          su2_pkg::SU2_MODE_UART8: begin
            tx_sh_r  <= {1'b1, 1'b1, pwdata_i[7:0], 1'b0};
            tx_cnt_r <= 4'd10;
          end
          default: begin
            tx_sh_r  <= {1'b1, ctl_r[su2_pkg::CTL_TX_NINTH], pwdata_i[7:0], 1'b0};
            tx_cnt_r <= 4'd11;
          end
        endcase
      end else if (tx_busy_r && shift_edge) begin
        if (mode != su2_pkg::SU2_MODE_SHIFT && !tx_go_r) begin
          // wait for the bit clock so the start bit lasts a whole bit
          tx_go_r <= 1'b1;
        end else if (mode == su2_pkg::SU2_MODE_SHIFT) begin
          m0_clk_r <= ~m0_clk_r;
          if (!m0_clk_r) begin
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
          end
        end else begin
          tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
        end
        if (tx_cnt_r == 4'h1 && (mode != su2_pkg::SU2_MODE_SHIFT || !m0_clk_r)) begin
          tx_busy_r <= 1'b0;
          set_tx    <= 1'b1;
        end
      end
    end
  end

  // ---------------- receiver ----------------
  logic [9:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic       rx_busy_r, rx_prev_r, rx_phase_r;
  logic [3:0] rx_need;
  assign rx_need = (mode == su2_pkg::SU2_MODE_UART8) ? 4'd9 : 4'd10;

  // half-bit phase restarts at each start edge, so samples never straddle a bit edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !rx_busy_r) begin
      rx_phase_r <= 1'b0;
    end else if (samp) begin
      rx_phase_r <= ~rx_phase_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_sh_r    <= 10'h000;
      rx_cnt_r   <= 4'h0;
      rx_busy_r  <= 1'b0;
      rx_prev_r  <= 1'b1;
      set_rx     <= 1'b0;
      set_rb8    <= 1'b0;
      rb8_val    <= 1'b0;
      rx_latch_r <= su2_pkg::RST_BYTE;
    end else begin
      set_rx  <= 1'b0;
      set_rb8 <= 1'b0;
      rx_prev_r <= rx_i;
      if (!ctl_r[su2_pkg::CTL_RX_EN]) begin
        rx_busy_r <= 1'b0;
      end else if (mode == su2_pkg::SU2_MODE_SHIFT) begin
        // mode 0 reception shifts on the same clock the transmit pin drives
        if (!rx_busy_r && !ctl_r[su2_pkg::CTL_RX_DONE] && !tx_busy_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= 4'd8;
        end else if (rx_busy_r && m0_tick && !m0_clk_r) begin
          rx_sh_r  <= {rx_sh_r[9:8], rx_i, rx_sh_r[7:1]};
          rx_cnt_r <= rx_cnt_r - 4'h1;
          if (rx_cnt_r == 4'h1) begin
            rx_busy_r  <= 1'b0;
            rx_latch_r <= {rx_i, rx_sh_r[7:1]};
            set_rx     <= 1'b1;
          end
        end
      end else if (!rx_busy_r) begin
        if (rx_prev_r && !rx_i) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= 4'h0;
        end
      end else if (samp && !rx_phase_r) begin
        // one sample per bit, in its first half, phased from the start edge
        rx_sh_r  <= {rx_i, rx_sh_r[9:1]};
        rx_cnt_r <= rx_cnt_r + 4'h1;
        if (rx_cnt_r == rx_need) begin
          rx_busy_r <= 1'b0;
          if (accept(rx_i, rx_sh_r)) begin
            rx_latch_r <= (mode == su2_pkg::SU2_MODE_UART8) ? rx_sh_r[9:2] : rx_sh_r[8:1];
            set_rx     <= 1'b1;
            set_rb8    <= 1'b1;
            // stop bit in mode 1, ninth bit in modes 2/3
            rb8_val    <= (mode == su2_pkg::SU2_MODE_UART8) ? rx_i : rx_sh_r[9];
          end
        end
      end
    end
  end

  function automatic logic accept(input logic last, input logic [9:0] sh);
    logic [7:0] b;
    logic       nine;
    b    = (mode == su2_pkg::SU2_MODE_UART8) ? sh[9:2] : sh[8:1];
    nine = sh[9];
    if (ctl_r[su2_pkg::CTL_RX_DONE]) begin
      accept = 1'b0;
    end else if (!ctl_r[su2_pkg::CTL_ADDR_REC]) begin
      accept = 1'b1;
    end else if (mode == su2_pkg::SU2_MODE_UART8) begin
      accept = last && (b == OWN_ADDR || b == su2_pkg::BROADCAST_ADDR);
    end else begin
      accept = nine && (b == OWN_ADDR || b == su2_pkg::BROADCAST_ADDR);
    end
  endfunction

  // ---------------- registers ----------------
  assign clr_tx = wr && idx == 10'(su2_pkg::IDX_SERIAL2_CONTROL) && !pwdata_i[su2_pkg::CTL_TX_DONE];
  assign clr_rx = wr && idx == 10'(su2_pkg::IDX_SERIAL2_CONTROL) && !pwdata_i[su2_pkg::CTL_RX_DONE];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctl_r <= su2_pkg::RST_BYTE;
    end else begin
      if (wr && idx == 10'(su2_pkg::IDX_SERIAL2_CONTROL)) begin
        ctl_r[7:3] <= pwdata_i[7:3];
        ctl_r[su2_pkg::CTL_RX_NINTH] <= pwdata_i[su2_pkg::CTL_RX_NINTH];
      end
      if (set_rb8) begin
        ctl_r[su2_pkg::CTL_RX_NINTH] <= rb8_val;
      end
      // set wins over a software clear in the same cycle
      ctl_r[su2_pkg::CTL_TX_DONE] <= set_tx | (ctl_r[su2_pkg::CTL_TX_DONE] & ~clr_tx);
      ctl_r[su2_pkg::CTL_RX_DONE] <= set_rx | (ctl_r[su2_pkg::CTL_RX_DONE] & ~clr_rx);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aux_r    <= su2_pkg::RST_BYTE;
      reload_r <= su2_pkg::RST_BYTE;
      ie_r     <= su2_pkg::RST_BYTE;
      ie2_r    <= su2_pkg::RST_BYTE;
      pl_r     <= su2_pkg::RST_BYTE;
      ph_r     <= su2_pkg::RST_BYTE;
    end else if (wr) begin
      unique case (idx)
        10'(su2_pkg::IDX_AUX_CONTROL):  aux_r    <= pwdata_i[7:0];
        10'(su2_pkg::IDX_BAUD_RELOAD):  reload_r <= pwdata_i[7:0];
        10'(su2_pkg::IDX_INT_ENABLE):   ie_r     <= pwdata_i[7:0] & su2_pkg::IE_WMASK;
        10'(su2_pkg::IDX_INT_ENABLE2):  ie2_r    <= pwdata_i[7:0] & su2_pkg::IE2_WMASK;
        10'(su2_pkg::IDX_PRIO_LOW):     pl_r     <= pwdata_i[7:0] & su2_pkg::IE2_WMASK;
        10'(su2_pkg::IDX_PRIO_HIGH):    ph_r     <= pwdata_i[7:0] & su2_pkg::IE2_WMASK;
        default: ;
      endcase
    end
  end

  always_comb begin
    hit = 1'b1;
    unique case (idx)
      10'(su2_pkg::IDX_AUX_CONTROL), 10'(su2_pkg::IDX_SERIAL2_CONTROL),
      10'(su2_pkg::IDX_SERIAL2_BUFFER), 10'(su2_pkg::IDX_BAUD_RELOAD),
      10'(su2_pkg::IDX_INT_ENABLE), 10'(su2_pkg::IDX_INT_ENABLE2),
      10'(su2_pkg::IDX_PRIO_LOW), 10'(su2_pkg::IDX_PRIO_HIGH): hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // apb answer: registered at the setup cycle's edge, pready high in the access cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~hit;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (idx)
          10'(su2_pkg::IDX_AUX_CONTROL):     prdata_o[7:0] <= aux_r;
          10'(su2_pkg::IDX_SERIAL2_CONTROL): prdata_o[7:0] <= ctl_r;
          10'(su2_pkg::IDX_SERIAL2_BUFFER):  prdata_o[7:0] <= rx_latch_r;
          10'(su2_pkg::IDX_BAUD_RELOAD):     prdata_o[7:0] <= reload_r;
          10'(su2_pkg::IDX_INT_ENABLE):      prdata_o[7:0] <= ie_r;
          10'(su2_pkg::IDX_INT_ENABLE2):     prdata_o[7:0] <= ie2_r;
          10'(su2_pkg::IDX_PRIO_LOW):        prdata_o[7:0] <= pl_r;
          10'(su2_pkg::IDX_PRIO_HIGH):       prdata_o[7:0] <= ph_r;
          default: ;
        endcase
      end
    end
  end

  // pins and interrupt
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_o         <= 1'b1;
      rx_o         <= 1'b1;
      rx_oe_o      <= 1'b0;
      irq_o        <= 1'b0;
      irq_prio_o   <= 2'b00;
      s1_use_brt_o <= 1'b0;
      brt_ovf_o    <= 1'b0;
    end else begin
      if (mode == su2_pkg::SU2_MODE_SHIFT) begin
        tx_o    <= tx_busy_r ? m0_clk_r : 1'b1;
        rx_o    <= tx_sh_r[0];
        rx_oe_o <= tx_busy_r;
      end else begin
        tx_o    <= (tx_busy_r && tx_go_r) ? tx_sh_r[0] : 1'b1;
        rx_o    <= 1'b1;
        rx_oe_o <= 1'b0;
      end
      irq_o <= ie_r[su2_pkg::IE_GLOBAL] & ie2_r[su2_pkg::IE2_SERIAL2]
               & (ctl_r[su2_pkg::CTL_TX_DONE] | ctl_r[su2_pkg::CTL_RX_DONE]);
      irq_prio_o   <= {ph_r[su2_pkg::PRIO_SERIAL2], pl_r[su2_pkg::PRIO_SERIAL2]};
      s1_use_brt_o <= aux_r[su2_pkg::AUX_S1_SRC];
      brt_ovf_o    <= ovf;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_irq_gate; !ie_r[su2_pkg::IE_GLOBAL] |=> !irq_o; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq with global off");
  property p_irq_en; !ie2_r[su2_pkg::IE2_SERIAL2] |=> !irq_o; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq with serial2 off");
  property p_tx_start; tx_wr |=> tx_busy_r; endproperty
  a_tx_start: assert property (p_tx_start) else $error("write did not start transmit");
  property p_tx_done; set_tx |=> ctl_r[su2_pkg::CTL_TX_DONE]; endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done not set");
  property p_rx_done; set_rx |=> ctl_r[su2_pkg::CTL_RX_DONE]; endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx done not set");
  property p_rx_off;
    !ctl_r[su2_pkg::CTL_RX_EN] ##1 !ctl_r[su2_pkg::CTL_RX_EN] |-> !set_rx;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("reception while disabled");
  property p_prio; ##1 irq_prio_o == {$past(ph_r[0]), $past(pl_r[0])}; endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  property p_idle_tx;
    !tx_busy_r && !tx_wr && mode != su2_pkg::SU2_MODE_SHIFT |=> tx_o;
  endproperty
  a_idle_tx: assert property (p_idle_tx) else $error("line not idle high");
endmodule

// ===== bench/su2_peer.sv
// remote serial peer: frame capture on tx and frame generation on rx
`timescale 1ns/1ps
module su2_peer (
  // clock
  input  wire logic clk_i,
  // serial lines
  input  wire logic tx_i,
  output logic      rx_o
);
  int          bit_cyc = 16;
  int          nbits = 10;
  int          got_cnt = 0;
  logic [10:0] got = 11'h000;
  initial rx_o = 1'b1;
  // sample start, data lsb first, optional ninth, stop mid-bit
  always begin
    @(negedge tx_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      got[i] = tx_i;
      repeat (bit_cyc) @(posedge clk_i);
    end
    got_cnt++;
  end
  // send start 0, data lsb first, ninth in 11-bit frames, stop 1
  task automatic send(input logic [8:0] d, input int nb);
    for (int i = 0; i < nb; i++) begin
      rx_o <= (i == 0) ? 1'b0 : (i == nb - 1) ? 1'b1 : d[i-1];
      repeat (bit_cyc) @(posedge clk_i);
    end
  endtask
endmodule

// ===== bench/tb.sv
// self-checking bench for the serial-2 block
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [1:0]  irq_prio_o;
  logic        pready_o, pslverr_o, rx_i, rx_o, rx_oe_o, tx_o, irq_o, s1_use_brt_o, brt_ovf_o;
  logic        peer_rx, er;
  int          err_total = 0;
  int          check_count = 0;
  int          n;
  always #20 clk_i = ~clk_i;
  assign rx_i = rx_oe_o ? rx_o : peer_rx;
  su2_uart su2_uart_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
    .rx_o(rx_o), .rx_oe_o(rx_oe_o), .tx_o(tx_o), .irq_o(irq_o), .irq_prio_o(irq_prio_o),
    .s1_use_brt_o(s1_use_brt_o), .brt_ovf_o(brt_ovf_o));
  su2_peer su2_peer_inst (.clk_i(clk_i), .tx_i(tx_o), .rx_o(peer_rx));
  task automatic give_verdict();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, {24'h000000, e}, rd);
  endtask
  task automatic gap(output int k);
    for (int i = 0; i < 400 && brt_ovf_o !== 1'b1; i++)
      @(posedge clk_i);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (k < 100 && brt_ovf_o !== 1'b1);
  endtask
  task automatic tx_frame(input logic [7:0] d, input int nb, input logic [10:0] e);
    su2_peer_inst.nbits = nb;
    n = su2_peer_inst.got_cnt;
    apb(1'b1, su2_pkg::IDX_SERIAL2_BUFFER, d);
    for (int i = 0; i < 2000 && su2_peer_inst.got_cnt == n; i++)
      @(posedge clk_i);
    chk("tx frame", {21'h000000, e}, {21'h000000, su2_peer_inst.got});
  endtask
  initial begin
    #800000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk("control", su2_pkg::IDX_SERIAL2_CONTROL, 8'h00);
    rchk("aux", su2_pkg::IDX_AUX_CONTROL, 8'h00);
    apb(1'b1, su2_pkg::IDX_BAUD_RELOAD, 8'hA7);
    rchk("reload", su2_pkg::IDX_BAUD_RELOAD, 8'hA7);
    apb(1'b1, su2_pkg::IDX_INT_ENABLE2, 8'hFF);
    rchk("ie2", su2_pkg::IDX_INT_ENABLE2, 8'h03);
    apb(1'b1, 8'h10, 8'h55);
    chk("slverr", 32'h1, {31'h0, er});
    rchk("unmapped", 8'h10, 8'h00);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, su2_pkg::IDX_PRIO_LOW, {7'h00, p[0]});
      apb(1'b1, su2_pkg::IDX_PRIO_HIGH, {7'h00, p[1]});
      repeat (2) @(negedge clk_i);
      chk("prio", p, {30'h0, irq_prio_o});
    end
    apb(1'b1, su2_pkg::IDX_AUX_CONTROL, 8'h01);
    repeat (2) @(negedge clk_i);
    chk("s1 src", 32'h1, {31'h0, s1_use_brt_o});
    apb(1'b1, su2_pkg::IDX_BAUD_RELOAD, 8'hF0);
    apb(1'b1, su2_pkg::IDX_AUX_CONTROL, 8'h14);
    gap(n);
    chk("ovf x1", 32'd16, n);
    apb(1'b1, su2_pkg::IDX_BAUD_RELOAD, 8'hFE);
    apb(1'b1, su2_pkg::IDX_AUX_CONTROL, 8'h10);
    gap(n);
    gap(n);
    chk("ovf x12", 32'd24, n);
    apb(1'b1, su2_pkg::IDX_AUX_CONTROL, 8'h00);
    repeat (4) @(posedge clk_i);
    n = 0;
    repeat (60) begin
      @(posedge clk_i);
      n += int'(brt_ovf_o === 1'b1);
    end
    chk("ovf stopped", 32'd0, n);
    apb(1'b1, su2_pkg::IDX_BAUD_RELOAD, 8'hFF);
    apb(1'b1, su2_pkg::IDX_AUX_CONTROL, 8'h1C);
    apb(1'b1, su2_pkg::IDX_INT_ENABLE, 8'h80);
    apb(1'b1, su2_pkg::IDX_INT_ENABLE2, 8'h01);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'h50);
    tx_frame(8'h3C, 10, 11'h278);
    rchk("tx done", su2_pkg::IDX_SERIAL2_CONTROL, 8'h52);
    chk("irq on", 32'h1, {31'h0, irq_o});
    apb(1'b1, su2_pkg::IDX_INT_ENABLE, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("irq global", 32'h0, {31'h0, irq_o});
    apb(1'b1, su2_pkg::IDX_INT_ENABLE, 8'h80);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'h50);
    repeat (2) @(negedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    su2_peer_inst.send(9'h0A5, 10);
    rchk("rx mode1", su2_pkg::IDX_SERIAL2_CONTROL, 8'h55);
    rchk("rx data", su2_pkg::IDX_SERIAL2_BUFFER, 8'hA5);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'h40);
    su2_peer_inst.send(9'h0C3, 10);
    apb(1'b0, su2_pkg::IDX_SERIAL2_CONTROL, 8'h00);
    chk("rx off", 32'h0, {31'h0, rd[0]});
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'hD8);
    tx_frame(8'h81, 11, 11'h702);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'hD0);
    su2_peer_inst.send(9'h15A, 11);
    rchk("rx mode3", su2_pkg::IDX_SERIAL2_CONTROL, 8'hD5);
    rchk("rx data3", su2_pkg::IDX_SERIAL2_BUFFER, 8'h5A);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'hF0);
    su2_peer_inst.send(9'h112, 11);
    apb(1'b0, su2_pkg::IDX_SERIAL2_CONTROL, 8'h00);
    chk("addr miss", 32'h0, {31'h0, rd[0]});
    su2_peer_inst.send(9'h1FF, 11);
    apb(1'b0, su2_pkg::IDX_SERIAL2_CONTROL, 8'h00);
    chk("addr hit", 32'h1, {31'h0, rd[0]});
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'h70);
    su2_peer_inst.send(9'h012, 10);
    apb(1'b0, su2_pkg::IDX_SERIAL2_CONTROL, 8'h00);
    chk("addr miss m1", 32'h0, {31'h0, rd[0]});
    su2_peer_inst.send(9'h000, 10);
    rchk("addr hit m1", su2_pkg::IDX_SERIAL2_CONTROL, 8'h75);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'h98);
    su2_peer_inst.bit_cyc = 32;
    tx_frame(8'h81, 11, 11'h702);
    apb(1'b1, su2_pkg::IDX_SERIAL2_CONTROL, 8'h00);
    apb(1'b1, su2_pkg::IDX_SERIAL2_BUFFER, 8'hA5);
    repeat (120) @(posedge clk_i);
    rchk("mode0 done", su2_pkg::IDX_SERIAL2_CONTROL, 8'h02);
    give_verdict();
  end
endmodule
